// >>> design/svw_pkg.sv
package svw_pkg;
  // register offsets
  localparam logic [7:0] A_SEC_DEP = 8'h13;
  localparam logic [7:0] A_SEC_CFG = 8'h14;
  localparam logic [7:0] A_WD_CFG = 8'h15;
  localparam logic [7:0] A_LOCK = 8'h16;
  localparam logic [7:0] A_FLT_P = 8'h28;
  localparam logic [7:0] A_FLT_S = 8'h29;
  localparam logic [7:0] A_FLT_O = 8'h2a;
  // nonvolatile areas and commands
  localparam logic [7:0] NV_USR_LO = 8'h40;
  localparam logic [7:0] NV_USR_HI = 8'h7f;
  localparam logic [7:0] NV_CFG_LO = 8'h80;
  localparam logic [7:0] NV_CFG_HI = 8'h97;
  localparam logic [7:0] NV_LOCK_ADDR = 8'h96;
  localparam logic [7:0] REBOOT_CMD = 8'hc4;
  localparam logic [7:0] CFG_LAST = 8'h17;
  // field positions
  localparam int OD_BIT = 0;
  localparam int DLY_LSB = 1;
  localparam int WDI_LSB = 1;
  localparam int WDN_LSB = 4;
  localparam int WD_EN_BIT = 7;
  localparam int LOCK_BIT = 3;
  localparam int WP_RST_BIT = 1;
  localparam int WP_SEC_BIT = 0;
  localparam int FO_SEC = 0;
  localparam int FO_RST = 1;
  localparam int FO_WD = 7;
  localparam int PIN_MR = 0;
  localparam int PIN_HOLD = 1;
  localparam int PIN_KICK = 2;
  // reset values
  localparam logic [7:0] RST_SEC_DEP = 8'h01;
  localparam logic [7:0] RST_SEC_CFG = 8'h01;
  localparam logic [7:0] RST_WD_CFG = 8'h01;
  localparam logic [2:0] PIN_IDLE = 3'h3;
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PWRUP_DLY_NS = 5000;
  localparam int PWRUP_CYC = (PWRUP_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WD_PULSE_NS = 2000;
  localparam int WD_PULSE_CYC = WD_PULSE_NS / CLK_PERIOD_NS;
  localparam int NV_WR_MS = 11;
  localparam int NV_WR_CYC_DEF = NV_WR_MS * 1000000 / CLK_PERIOD_NS;
  // delays in 1 us ticks, index = 3-bit code
  localparam logic [26:0] REL_US [8] = '{27'h19, 27'h618, 27'h186a,
    27'h61a8, 27'hc350, 27'h30d40, 27'h61a80, 27'h186a00};
  localparam logic [26:0] WD_US [8] = '{27'h186a, 27'h61a8, 27'h186a0,
    27'h61a80, 27'h186a00, 27'h61a800, 27'h186a000, 27'h61a8000};
  typedef enum logic [1:0] {BT_WAIT = 2'b00, BT_COPY = 2'b01, BT_RUN = 2'b10} svw_boot_e;
  typedef enum logic [2:0] {WD_OFF = 3'b000, WD_INIT = 3'b001, WD_NORM = 3'b010,
    WD_PULSE = 3'b011, WD_HOLD = 3'b100} svw_wd_e;
endpackage

// >>> design/svw_supervisor.sv
`timescale 1ns/1ps
// Functional notes
// - alarm dependency: bit0 manual reset, bit1 reset output, bits2-7 inputs 1-6
// - alarm pin open drain when config bit0 set, weak pullup otherwise
// - alarm release delay code picks 25us up to 1600ms
// - initial watchdog period code picks 6.25ms up to 102.4s
// - normal watchdog period uses the same table from bits 6:4
// - watchdog runs only while its enable bit is set
// - watchdog pin open drain when config bit0 set, weak pullup otherwise
// - initial period starts at power-up, reset event, enable and expiry
// - normal periods follow; host must kick within each one
// - expiry gives a short pulse when reset output depends on watchdog
// - otherwise expiry holds fault until any kick edge
// - fault flags read only, volatile; a read clears its register
// - first fault read after power-up is invalid; host discards it
// - primary undervoltage of input n sets bit n-1 of primary flags
// - secondary threshold violation of input n sets bit n-1
// - output flags: bit0 alarm, bit1 reset output, bit7 watchdog
// - lock bit rejects config writes except to the lock bit
// - user memory writes blocked while selected outputs are asserted
// - register writes act at once without touching the stored copy
// - stored configuration copied into registers at power-up and reboot
// - internal 1MHz clock starts 5us after supply, then copy begins
// - access denied while the copy runs, within 2.5ms
// - a memory byte write may take 11ms before the next
// - output stays asserted for its delay after conditions clear
// - output with no dependency selected stays asserted
// - test hold low freezes outputs, overriding manual reset
// - send-byte C4h reboots and reloads configuration
module svw_supervisor import svw_pkg::*; #(
  parameter int TIME_SHIFT = 0,
  parameter int NV_WR_CYC = NV_WR_CYC_DEF
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic manual_reset_input_n_i,
  input wire logic test_hold_n_i,
  input wire logic watchdog_kick_input_i,
  input wire logic [5:0] monitored_inputs_uv_i,
  input wire logic [5:0] monitored_inputs_sec_i,
  input wire logic reset_out_active_i,
  input wire logic reset_dep_wd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic send_byte_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] nv_rdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_ack_o,
  output logic reg_refused_o,
  output logic nv_rd_o,
  output logic nv_wr_o,
  output logic [7:0] nv_addr_o,
  output logic [7:0] nv_wdata_o,
  output logic secondary_alarm_output_n_o,
  output logic secondary_alarm_od_o,
  output logic watchdog_fault_output_n_o,
  output logic watchdog_fault_od_o,
  output logic config_busy_o
);

  // refuse settings the counters cannot hold
  if (TIME_SHIFT < 0 || TIME_SHIFT > 20 || NV_WR_CYC < 1 || NV_WR_CYC > 1048575) begin : g_bad
    $error("svw_supervisor: unsupported parameter value");
  end

  typedef struct packed {
    svw_boot_e boot;
    logic [7:0] bcnt;
    logic [5:0] tcnt;
    logic tick;
    logic [2:0][2:0] pin_sy;
    logic [2:0] pin_f;
    logic [7:0] dep;
    logic [7:0] sec;
    logic [7:0] wdc;
    logic [7:0] lck;
    logic [7:0] flt_p;
    logic [7:0] flt_s;
    logic [7:0] flt_o;
    logic rd_seen;
    logic sec_act;
    logic [26:0] sec_cnt;
    svw_wd_e wd;
    logic [26:0] wd_cnt;
    logic wd_act;
    logic wd_en_d;
    logic rst_d;
    logic nv_rd;
    logic nv_cap;
    logic nv_wr;
    logic [7:0] nv_addr;
    logic [7:0] nv_wdata;
    logic [19:0] nv_busy;
    logic [7:0] rdata;
    logic ack;
    logic refused;
  } svw_state_s;

  // outputs asserted (low) from reset; watchdog until the first copy ends, alarm until its release delay after
  localparam svw_state_s RST_S = '{boot: BT_WAIT, pin_sy: {3{PIN_IDLE}}, pin_f: PIN_IDLE,
    dep: RST_SEC_DEP, sec: RST_SEC_CFG, wdc: RST_WD_CFG, sec_act: 1'b1, wd_act: 1'b1,
    wd: WD_OFF, default: '0};

  svw_state_s s;
  svw_state_s n;
  logic run;
  logic hold;
  logic mr_act;
  logic kick_ev;
  logic [2:0] agree;
  logic any_cond;
  logic [26:0] rel;
  logic [26:0] per;
  logic en_rise;
  logic rst_rise;
  logic locked;
  logic cfg_nv;
  logic usr_nv;
  logic wp;

  always_comb begin
    n = s;
    n.tick = 1'b0;
    n.ack = 1'b0;
    n.refused = 1'b0;
    n.nv_rd = 1'b0;
    n.nv_wr = 1'b0;
    n.rdata = 8'h00;
    run = (s.boot == BT_RUN);
    locked = s.lck[LOCK_BIT];

    // pins: three stages, a change counts once stages two and three agree
    agree = ~(s.pin_sy[1] ^ s.pin_sy[2]);
    n.pin_sy = {s.pin_sy[1:0], watchdog_kick_input_i, test_hold_n_i, manual_reset_input_n_i};
    n.pin_f = (agree & s.pin_sy[2]) | (~agree & s.pin_f);
    mr_act = ~s.pin_f[PIN_MR];
    hold = ~s.pin_f[PIN_HOLD];
    kick_ev = agree[PIN_KICK] & (s.pin_sy[2][PIN_KICK] ^ s.pin_f[PIN_KICK]);

    // 1 MHz time base, stopped until the start-up delay has passed
    if (s.boot != BT_WAIT) begin
      n.tcnt = s.tcnt + 6'h1;
      if (s.tcnt == 6'(TICK_CYC - 1)) begin
        n.tcnt = 6'h00;
        n.tick = 1'b1;
      end
    end

    // start-up delay, then walk the stored configuration area
    n.nv_cap = s.nv_rd;
    unique case (s.boot)
      BT_WAIT: begin
        n.bcnt = s.bcnt + 8'h01;
        if (s.bcnt == 8'(PWRUP_CYC - 1)) begin
          n.boot = BT_COPY;
          n.bcnt = 8'h00;
        end
      end
      BT_COPY: begin
        if (s.nv_cap) begin
          case (s.nv_addr)
            NV_CFG_LO | A_SEC_DEP: n.dep = nv_rdata_i;
            NV_CFG_LO | A_SEC_CFG: n.sec = nv_rdata_i;
            NV_CFG_LO | A_WD_CFG: n.wdc = nv_rdata_i;
            NV_CFG_LO | A_LOCK: n.lck = nv_rdata_i;
            default: ;
          endcase
          n.bcnt = s.bcnt + 8'h01;
          if (s.bcnt == CFG_LAST) begin
            n.boot = BT_RUN;
          end
        end else if (!s.nv_rd) begin
          n.nv_rd = 1'b1;
          n.nv_addr = NV_CFG_LO + s.bcnt;
        end
      end
      BT_RUN: ;
    endcase

    // secondary alarm: OR of the selected conditions, none selected means asserted
    any_cond = (s.dep == 8'h00)
      | (|(s.dep & {monitored_inputs_sec_i, reset_out_active_i, mr_act}));
    rel = REL_US[s.sec[DLY_LSB +: 3]] >> TIME_SHIFT;
    if (rel == 27'h0) begin
      rel = 27'h1;
    end
    // test hold freezes the alarm state, so it also masks manual reset
    if (run && !hold) begin
      if (any_cond) begin
        n.sec_act = 1'b1;
        n.sec_cnt = 27'h0;
      end else if (s.sec_act && s.tick) begin
        n.sec_cnt = s.sec_cnt + 27'h1;
        if (s.sec_cnt >= rel - 27'h1) begin
          n.sec_act = 1'b0;
        end
      end
    end

    // watchdog: timeouts counted in ticks, pulse counted in clocks
    per = WD_US[(s.wd == WD_INIT) ? s.wdc[WDI_LSB +: 3] : s.wdc[WDN_LSB +: 3]] >> TIME_SHIFT;
    if (per == 27'h0) begin
      per = 27'h1;
    end
    en_rise = s.wdc[WD_EN_BIT] & ~s.wd_en_d;
    rst_rise = reset_out_active_i & ~s.rst_d;
    n.wd_en_d = s.wdc[WD_EN_BIT];
    n.rst_d = reset_out_active_i;
    if (run) begin
      if (!s.wdc[WD_EN_BIT]) begin
        n.wd = WD_OFF;
        n.wd_cnt = 27'h0;
      end else if (en_rise || rst_rise) begin
        n.wd = WD_INIT;
        n.wd_cnt = 27'h0;
      end else begin
        unique case (s.wd)
          WD_OFF: begin
            n.wd = WD_INIT;
            n.wd_cnt = 27'h0;
          end
          WD_INIT, WD_NORM: begin
            if (kick_ev) begin
              n.wd = WD_NORM;
              n.wd_cnt = 27'h0;
            end else if (s.tick) begin
              n.wd_cnt = s.wd_cnt + 27'h1;
              if (s.wd_cnt >= per - 27'h1) begin
                n.wd = reset_dep_wd_i ? WD_PULSE : WD_HOLD;
                n.wd_cnt = 27'h0;
              end
            end
          end
          WD_PULSE: begin
            n.wd_cnt = s.wd_cnt + 27'h1;
            if (s.wd_cnt == 27'(WD_PULSE_CYC - 1)) begin
              n.wd = WD_INIT;
              n.wd_cnt = 27'h0;
            end
          end
          WD_HOLD: begin
            if (kick_ev) begin
              n.wd = WD_INIT;
              n.wd_cnt = 27'h0;
            end
          end
          default: n.wd = WD_OFF;
        endcase
      end
      if (!hold) begin
        n.wd_act = (n.wd == WD_PULSE) || (n.wd == WD_HOLD);
      end
    end

    // register and memory access; the copy owns the bank while it runs
    n.ack = reg_rd_i | reg_wr_i | send_byte_i;
    cfg_nv = (reg_addr_i >= NV_CFG_LO) && (reg_addr_i <= NV_CFG_HI);
    usr_nv = (reg_addr_i >= NV_USR_LO) && (reg_addr_i <= NV_USR_HI);
    wp = (s.lck[WP_RST_BIT] && reset_out_active_i) || (s.lck[WP_SEC_BIT] && s.sec_act);
    if (s.nv_busy != 20'h0) begin
      n.nv_busy = s.nv_busy - 20'h1;
    end
    if (!run) begin
      n.refused = n.ack;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        A_SEC_DEP: n.rdata = s.dep;
        A_SEC_CFG: n.rdata = s.sec;
        A_WD_CFG: n.rdata = s.wdc;
        A_LOCK: n.rdata = s.lck;
        A_FLT_P, A_FLT_S, A_FLT_O: begin
          // the first read after power-up returns zero and leaves flags alone
          n.rd_seen = 1'b1;
          if (s.rd_seen) begin
            n.rdata = (reg_addr_i == A_FLT_P) ? s.flt_p :
              (reg_addr_i == A_FLT_S) ? s.flt_s : s.flt_o;
            if (reg_addr_i == A_FLT_P) n.flt_p = 8'h00;
            if (reg_addr_i == A_FLT_S) n.flt_s = 8'h00;
            if (reg_addr_i == A_FLT_O) n.flt_o = 8'h00;
          end
        end
        default: n.refused = 1'b1;
      endcase
    end else if (reg_wr_i) begin
      if (reg_addr_i == A_LOCK) begin
        if (locked) begin
          n.lck[LOCK_BIT] = reg_wdata_i[LOCK_BIT];
        end else begin
          n.lck = reg_wdata_i;
        end
      end else if (reg_addr_i == A_SEC_DEP || reg_addr_i == A_SEC_CFG || reg_addr_i == A_WD_CFG) begin
        if (locked) begin
          n.refused = 1'b1;
        end else begin
          // takes effect at once, the stored copy is untouched
          if (reg_addr_i == A_SEC_DEP) n.dep = reg_wdata_i;
          if (reg_addr_i == A_SEC_CFG) n.sec = reg_wdata_i;
          if (reg_addr_i == A_WD_CFG) n.wdc = reg_wdata_i;
        end
      end else if (cfg_nv || usr_nv) begin
        if (s.nv_busy != 20'h0) begin
          n.refused = 1'b1;
        end else if (cfg_nv && locked && reg_addr_i != NV_LOCK_ADDR) begin
          n.refused = 1'b1;
        end else if (usr_nv && wp) begin
          n.refused = 1'b1;
        end else begin
          n.nv_wr = 1'b1;
          n.nv_addr = reg_addr_i;
          n.nv_wdata = reg_wdata_i;
          n.nv_busy = 20'(NV_WR_CYC);
        end
      end else begin
        n.refused = 1'b1;
      end
    end else if (send_byte_i) begin
      if (reg_wdata_i == REBOOT_CMD) begin
        n.boot = BT_COPY;
        n.bcnt = 8'h00;
        n.nv_cap = 1'b0;
      end else begin
        n.refused = 1'b1;
      end
    end

    // sticky flags; a new event wins over a clearing read
    if (run) begin
      n.flt_p = n.flt_p | {2'b00, monitored_inputs_uv_i};
      n.flt_s = n.flt_s | {2'b00, monitored_inputs_sec_i};
      n.flt_o[FO_SEC] = n.flt_o[FO_SEC] | n.sec_act;
      n.flt_o[FO_RST] = n.flt_o[FO_RST] | reset_out_active_i;
      n.flt_o[FO_WD] = n.flt_o[FO_WD] | n.wd_act;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s <= RST_S;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata_o = s.rdata;
  assign reg_ack_o = s.ack;
  assign reg_refused_o = s.refused;
  assign nv_rd_o = s.nv_rd;
  assign nv_wr_o = s.nv_wr;
  assign nv_addr_o = s.nv_addr;
  assign nv_wdata_o = s.nv_wdata;
  assign secondary_alarm_output_n_o = ~s.sec_act;
  assign secondary_alarm_od_o = s.sec[OD_BIT];
  assign watchdog_fault_output_n_o = ~s.wd_act;
  assign watchdog_fault_od_o = s.wdc[OD_BIT];
  assign config_busy_o = (s.boot != BT_RUN);

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sec_dep_a: assert property (run && !hold && any_cond |=> s.sec_act)
    else $error("alarm not asserted on a selected condition");
  sec_nodep_a: assert property (run && !hold && s.dep == 8'h00 |=> s.sec_act)
    else $error("alarm without dependency not asserted");
  sec_rel_a: assert property ($fell(s.sec_act) |-> $past(!any_cond && s.tick && !hold))
    else $error("alarm released while a condition was active");
  wd_off_a: assert property (run && !s.wdc[WD_EN_BIT] |=> s.wd == WD_OFF)
    else $error("watchdog running while disabled");
  wd_en_a: assert property (run && en_rise |=> s.wd == WD_INIT)
    else $error("enable did not start initial period");
  wd_pulse_a: assert property ($rose(s.wd == WD_PULSE) |-> ##80 (s.wd != WD_PULSE))
    else $error("expiry pulse too long");
  wd_hold_a: assert property (run && s.wd == WD_HOLD && s.wdc[WD_EN_BIT] && !kick_ev && !rst_rise
    |=> s.wd == WD_HOLD)
    else $error("watchdog fault released without kick edge");
  flt_clr_a: assert property (run && reg_rd_i && reg_addr_i == A_FLT_P && s.rd_seen
    && monitored_inputs_uv_i == 6'h00 |=> s.flt_p == 8'h00)
    else $error("primary flags not cleared by read");
  first_rd_a: assert property (run && reg_rd_i && !s.rd_seen
    && (reg_addr_i == A_FLT_P || reg_addr_i == A_FLT_S || reg_addr_i == A_FLT_O) |=> reg_rdata_o == 8'h00)
    else $error("first fault read not blanked");
  lock_a: assert property (run && reg_wr_i && reg_addr_i == A_WD_CFG && locked |=> $stable(s.wdc))
    else $error("locked register written");
  busy_a: assert property (!run && reg_wr_i |=> reg_refused_o && !nv_wr_o)
    else $error("access during copy not refused");
  hold_a: assert property (run && hold |=> $stable(s.sec_act) && $stable(s.wd_act))
    else $error("outputs moved during test hold");

  wd_hold_c: cover property ($rose(s.wd == WD_HOLD));
  wd_pulse_c: cover property ($rose(s.wd == WD_PULSE));
  sec_rel_c: cover property ($fell(s.sec_act));
  reboot_c: cover property (run ##1 s.boot == BT_COPY);
endmodule

// >>> test/svw_nv_model.sv
`timescale 1ns/1ps
// stored configuration array on the far side of the copy link
module svw_nv_model (
  input wire logic clk_i,
  input wire logic nv_rd_i,
  input wire logic nv_wr_i,
  input wire logic [7:0] nv_addr_i,
  input wire logic [7:0] nv_wdata_i,
  output logic [7:0] nv_rdata_o
);
  logic [7:0] mem [256];

  // alarm on input 1, 25ms release, watchdog off, unlocked
  initial begin
    foreach (mem[i]) begin
      mem[i] = 8'h00;
    end
    mem[8'h93] = 8'h04;
    mem[8'h94] = 8'h06;
    mem[8'h95] = 8'h00;
    mem[8'h96] = 8'h00;
    nv_rdata_o = 8'h5a;
  end

  // data only valid the cycle after a read pulse; lines toggle otherwise so stale data never matches
  always @(posedge clk_i) begin
    if (nv_rd_i) begin
      nv_rdata_o <= mem[nv_addr_i];
    end else begin
      nv_rdata_o <= ~nv_rdata_o;
    end
    if (nv_wr_i) begin
      mem[nv_addr_i] <= nv_wdata_i;
    end
  end
endmodule

// >>> test/tb_top.sv
`timescale 1ns/1ps
module tb_top import svw_pkg::*; ();
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic mr_n = 1'b1, hold_n = 1'b1, kick = 1'b0, rst_act = 1'b0, dep_wd = 1'b0;
  logic [5:0] uv = 6'h00, sec = 6'h00;
  logic [7:0] addr = 8'h00, wdata = 8'h00, nv_rdata, rdata, nv_addr, nv_wdata, q;
  logic wr = 1'b0, rd = 1'b0, sb = 1'b0, nv_seen;
  logic ack, refused, nv_rd, nv_wr, al_n, al_od, wd_n, wd_od, busy;
  int errors = 0;
  int samples_checked = 0;
  int i, n;

  // 40 MHz
  always #12.5 clk_i = ~clk_i;

  // long counts shortened so the run stays small
  svw_supervisor #(.TIME_SHIFT(10), .NV_WR_CYC(50)) dut (.clk_i(clk_i), .reset_i(reset_i),
    .manual_reset_input_n_i(mr_n), .test_hold_n_i(hold_n), .watchdog_kick_input_i(kick),
    .monitored_inputs_uv_i(uv), .monitored_inputs_sec_i(sec), .reset_out_active_i(rst_act),
    .reset_dep_wd_i(dep_wd), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .send_byte_i(sb),
    .reg_wdata_i(wdata), .nv_rdata_i(nv_rdata), .reg_rdata_o(rdata), .reg_ack_o(ack),
    .reg_refused_o(refused), .nv_rd_o(nv_rd), .nv_wr_o(nv_wr), .nv_addr_o(nv_addr),
    .nv_wdata_o(nv_wdata), .secondary_alarm_output_n_o(al_n), .secondary_alarm_od_o(al_od),
    .watchdog_fault_output_n_o(wd_n), .watchdog_fault_od_o(wd_od), .config_busy_o(busy));

  svw_nv_model nv (.clk_i(clk_i), .nv_rd_i(nv_rd), .nv_wr_i(nv_wr), .nv_addr_i(nv_addr),
    .nv_wdata_i(nv_wdata), .nv_rdata_o(nv_rdata));

  task automatic final_report();
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // 0 alarm, 1 watchdog fault, 2 busy
  function automatic logic outv(input int w);
    return (w == 0) ? al_n : (w == 1) ? wd_n : busy;
  endfunction

  // bounded wait; running out ends the run
  task automatic wait_out(input int w, input logic v, input int lim);
    for (int k = 0; k < lim && outv(w) !== v; k++) @(negedge clk_i);
    check({7'h00, outv(w)}, {7'h00, v});
    if (outv(w) !== v) final_report();
  endtask

  task automatic stay(input int w, input logic v, input int lim);
    for (int k = 0; k < lim && outv(w) === v; k++) @(negedge clk_i);
    check({7'h00, outv(w)}, {7'h00, v});
  endtask

  // one-cycle strobe; ack, data and refusal sampled in the cycle after the taking edge
  task automatic acc(input int k, input logic [7:0] a, input logic [7:0] d, input logic rf);
    @(negedge clk_i);
    addr = a;
    wdata = d;
    rd = (k == 0);
    wr = (k == 1);
    sb = (k == 2);
    @(negedge clk_i);
    rd = 1'b0;
    wr = 1'b0;
    sb = 1'b0;
    q = rdata;
    nv_seen = nv_wr;
    check({7'h00, ack}, 8'h01);
    check({7'h00, refused}, {7'h00, rf});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic rf);
    acc(0, a, 8'h00, rf);
    if (!rf) check(q, exp);
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    check({7'h00, busy}, 8'h01);
    rd_chk(A_SEC_DEP, 8'h00, 1'b1);
    acc(1, 8'h45, 8'h77, 1'b1);
    check({7'h00, nv_seen}, 8'h00);
    wait_out(2, 1'b0, 400);
    rd_chk(A_SEC_DEP, 8'h04, 1'b0);
    rd_chk(A_SEC_CFG, 8'h06, 1'b0);
    rd_chk(A_WD_CFG, 8'h00, 1'b0);
    rd_chk(A_LOCK, 8'h00, 1'b0);
    check({6'h00, al_od, wd_od}, 8'h00);
    rd_chk(A_FLT_P, 8'h00, 1'b0);
    rd_chk(8'h30, 8'h00, 1'b1);
    // alarm: unselected input ignored, selected one asserts, release after 24 ticks
    wait_out(0, 1'b1, 1200);
    sec = 6'h02;
    stay(0, 1'b1, 50);
    sec = 6'h03;
    wait_out(0, 1'b0, 3);
    sec = 6'h00;
    stay(0, 1'b0, 850);
    wait_out(0, 1'b1, 250);
    rd_chk(A_FLT_S, 8'h03, 1'b0);
    rd_chk(A_FLT_S, 8'h00, 1'b0);
    rd_chk(A_FLT_O, 8'h01, 1'b0);
    uv = 6'h20;
    repeat (2) @(negedge clk_i);
    uv = 6'h00;
    rd_chk(A_FLT_P, 8'h20, 1'b0);
    rd_chk(A_FLT_P, 8'h00, 1'b0);
    acc(1, A_FLT_P, 8'hff, 1'b1);
    acc(1, A_SEC_DEP, 8'h00, 1'b0);
    wait_out(0, 1'b0, 3);
    // manual reset dependency, short release, hold overriding manual reset
    acc(1, A_SEC_DEP, 8'h01, 1'b0);
    acc(1, A_SEC_CFG, 8'h03, 1'b0);
    @(negedge clk_i);
    check({7'h00, al_od}, 8'h01);
    wait_out(0, 1'b1, 100);
    hold_n = 1'b0;
    mr_n = 1'b0;
    stay(0, 1'b1, 20);
    hold_n = 1'b1;
    wait_out(0, 1'b0, 10);
    mr_n = 1'b1;
    // watchdog: initial 6 ticks, normal 24 ticks
    acc(1, A_WD_CFG, 8'h91, 1'b0);
    @(negedge clk_i);
    check({7'h00, wd_od}, 8'h01);
    stay(1, 1'b1, 180);
    wait_out(1, 1'b0, 140);
    stay(1, 1'b0, 300);
    kick = 1'b1;
    wait_out(1, 1'b1, 10);
    repeat (50) @(negedge clk_i);
    kick = 1'b0;
    stay(1, 1'b1, 850);
    wait_out(1, 1'b0, 300);
    for (i = 0; i < 8; i++) begin
      kick = ~kick;
      // the first edge only leaves the held fault after the pin synchroniser
      if (i == 0) wait_out(1, 1'b1, 10);
      stay(1, 1'b1, 150);
    end
    dep_wd = 1'b1;
    wait_out(1, 1'b0, 1100);
    n = 0;
    while (wd_n === 1'b0 && n < 300) begin
      n++;
      @(negedge clk_i);
    end
    check({7'h00, n > 0 && n < 200}, 8'h01);
    rd_chk(A_FLT_O, 8'h81, 1'b0);
    acc(1, A_WD_CFG, 8'h11, 1'b0);
    stay(1, 1'b1, 400);
    // lock blocks configuration writes but not the lock bit
    acc(1, A_LOCK, 8'h08, 1'b0);
    acc(1, A_SEC_DEP, 8'hff, 1'b1);
    acc(1, A_WD_CFG, 8'hff, 1'b1);
    rd_chk(A_WD_CFG, 8'h11, 1'b0);
    acc(1, 8'h93, 8'hff, 1'b1);
    rd_chk(A_SEC_DEP, 8'h01, 1'b0);
    acc(1, A_LOCK, 8'h00, 1'b0);
    acc(1, A_SEC_DEP, 8'h84, 1'b0);
    check({7'h00, nv_seen}, 8'h00);
    rd_chk(A_SEC_DEP, 8'h84, 1'b0);
    // user memory protection and write cycle spacing
    acc(1, A_LOCK, 8'h02, 1'b0);
    rst_act = 1'b1;
    acc(1, 8'h45, 8'h3c, 1'b1);
    rst_act = 1'b0;
    acc(1, 8'h45, 8'h3c, 1'b0);
    check({7'h00, nv_seen}, 8'h01);
    acc(1, 8'h46, 8'h11, 1'b1);
    check(nv.mem[8'h45], 8'h3c);
    repeat (60) @(negedge clk_i);
    check(nv.mem[8'h46], 8'h00);
    acc(1, 8'h46, 8'h11, 1'b0);
    // reboot reloads stored configuration
    acc(2, 8'h00, 8'h00, 1'b1);
    acc(2, 8'h00, REBOOT_CMD, 1'b0);
    check({7'h00, busy}, 8'h01);
    wait_out(2, 1'b0, 400);
    rd_chk(A_SEC_DEP, 8'h04, 1'b0);
    rd_chk(A_LOCK, 8'h00, 1'b0);
    final_report();
  end
endmodule
